// >>> rtl/pcrc_engine.sv
// Purpose: programmable crc generator fed by a byte or word fifo
// Assumes: one bit is shifted per SYS_CLK, the cpu strobes are one-cycle pulses
// Notes:   bytes are paired into fifo words; a lone byte waits in a staging slot
`timescale 1ns/1ns
`default_nettype none

// storage notes
// - the fifo always stores 16-bit words, whatever the length field says
// - byte mode keeps two bytes per word, high byte shifted first
// - a flush empties the pointers and may write slot zero in the same cycle
// - flush and push together leave exactly one word behind
// - a pop during a flush is dropped, the flushed data is gone anyway
// - ready drops only with all slots taken
// - the count field is one bit wider than the pointers
// - so full and empty are never confused
// - the storage array has no reset
// - stale words can sit on out_data while the count says empty, with out_valid low
//
// fifo of WIDTH x DEPTH words with valid and ready on both sides
module pcrc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0]   cnt;
	} pcrc_fifo_st_t;

	pcrc_fifo_st_t    st_ff;
	pcrc_fifo_st_t    nxt_st;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic             do_push;
	logic             do_pop;

	// handshake is honest: ready only with a free slot, valid only with data
	assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_ff.cnt != '0);
	assign out_data  = mem_ff[st_ff.rd];
	assign do_push   = in_valid && (in_ready || flush);
	assign do_pop    = out_valid && out_ready && !flush;

	// pointer and count update; flush drops everything, a push with it writes slot zero
	always_comb begin
		nxt_st = st_ff;
		if (flush) begin
			nxt_st.rd  = '0;
			nxt_st.wr  = do_push ? AW'(1 % DEPTH) : '0;
			nxt_st.cnt = do_push ? (AW+1)'(1) : '0;
		end else begin
			if (do_push) begin
				nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : AW'(st_ff.wr + 1'b1);
			end
			if (do_pop) begin
				nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : AW'(st_ff.rd + 1'b1);
			end
			nxt_st.cnt = (AW+1)'(st_ff.cnt + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0));
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// storage, no reset needed since count guards it
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_ff[flush ? AW'(0) : st_ff.wr] <= in_data;
		end
	end
endmodule // pcrc_fifo

// engine notes
// - one shift step per rising SYS_CLK edge, two per instruction cycle
// - the shift register is length bits wide, upper bits cleared by each shift step
// - the top term and the x0 term are wired, never taken from the taps
// - tap bits at or above the length have no effect
// - the element width is the length, upper bits of an element are ignored
// - an element takes length clocks; the count drops on its last bit
// - a partial element keeps its bit position while go is low
// - byte mode counts bytes, word mode counts words
// - a lone byte waits in a staging slot until its partner arrives
// - in byte mode a lone staged byte may be shifted on its own
// - in word mode a lone staged byte is never shifted
// - so the empty flag stays low until the pair completes
// - a write while full flushes fifo, stage and element progress
// - that write then counts from zero, the drain flag stays put
// - a direct preset beats a shift step in the same cycle
// - a drain flag set beats a clear in the same cycle
// - the fill count is not guarded against word writes near full
// - software is expected to watch the full flag before writing
//
// crc engine top
module pcrc_engine (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic [3:0]  POLY_LENGTH_FIELD,
	input  wire logic [15:0] POLY_TAP_REGISTER,
	input  wire logic        SHIFTER_GO_BIT,
	input  wire logic        DRAIN_IRQ_ENABLE,
	input  wire logic        DRAIN_IRQ_CLEAR,
	input  wire logic        DATA_WR,
	input  wire logic        DATA_WR_WORD,
	input  wire logic [15:0] DATA_IN,
	output logic             DATA_WR_READY,
	output logic [15:0]      DATA_RD_VALUE,
	input  wire logic        SR_WR,
	input  wire logic [15:0] SR_WDATA,
	output logic [15:0]      SR_RDATA,
	output logic [4:0]       FIFO_FILL_COUNT,
	output logic             FIFO_FULL_FLAG,
	output logic             FIFO_EMPTY_FLAG,
	output logic [15:0]      CONTROL_STATUS_REGISTER,
	output logic             DRAIN_IRQ_FLAG,
	output logic             DRAIN_IRQ
);
	typedef struct packed {
		logic [15:0] crc;
		logic [4:0]  count;
		logic [7:0]  stage;
		logic        stage_valid;
		logic        half;
		logic [3:0]  done;
		logic        full;
		logic        empty;
		logic        irq;
	} pcrc_st_t;

	pcrc_st_t    st_ff;
	pcrc_st_t    nxt_st;
	logic        word_mode;
	logic        flush;
	logic        push_en;
	logic [15:0] push_data;
	logic        pop;
	logic        fifo_ready;
	logic        head_valid;
	logic [15:0] head_data;
	logic        can_shift;
	logic        from_stage;
	logic [15:0] elem;
	logic [3:0]  pos;
	logic        din;
	logic        fb;
	logic        last_bit;
	logic [4:0]  base;
	logic        stage_in;
	logic [4:0]  inc;
	logic        dec;
	logic        irq_set;
	logic [15:0] crc_step;

	pcrc_fifo #(
		.WIDTH (pcrc_pkg::FIFO_WIDTH),
		.DEPTH (pcrc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst       (RST),
		.flush     (flush),
		.in_valid  (push_en),
		.in_ready  (fifo_ready),
		.in_data   (push_data),
		.out_valid (head_valid),
		.out_ready (pop),
		.out_data  (head_data)
	);

	// feedback is the top stage xor the incoming bit
	// the feedback enters stage zero directly
	// every other stage takes its lower neighbour
	// plus the feedback where its tap bit is set
	// stages above the length are cleared each step
	// one shift step; bits above the length read zero, tap bit zero unused
	assign fb = st_ff.crc[POLY_LENGTH_FIELD] ^ din;
	assign crc_step[0] = fb;
	for (genvar i = 1; i < 16; i++) begin : g_tap
		assign crc_step[i] = (i <= int'(POLY_LENGTH_FIELD)) ?
			(st_ff.crc[i-1] ^ (fb & POLY_TAP_REGISTER[i])) : 1'b0;
	end

	// next-state logic: cpu writes, serial shifting, flags
	always_comb begin
		nxt_st    = st_ff;
		word_mode = (POLY_LENGTH_FIELD > pcrc_pkg::LEN_BYTE_MAX);
		flush     = 1'b0;
		push_en   = 1'b0;
		push_data = DATA_IN;
		pop       = 1'b0;
		inc       = '0;
		dec       = 1'b0;
		irq_set   = 1'b0;
		stage_in  = st_ff.stage_valid;
		base      = st_ff.count;
		// a byte write either parks in the stage or completes a pair
		// a word write after a parked byte shifts the halves along
		// the high half of the new word completes the old pair
		// the low half becomes the new parked byte
		// the count increment follows the mode: bytes in byte mode, words in word mode
		// data port write; a write while full starts over from zero
		if (DATA_WR) begin
			if (st_ff.full) begin
				flush    = 1'b1;
				base     = pcrc_pkg::CNT_RST;
				stage_in = 1'b0;
				nxt_st.done = pcrc_pkg::DONE_RST;
				nxt_st.half = 1'b0;
			end
			nxt_st.stage_valid = stage_in;
			if (DATA_WR_WORD) begin
				push_en = 1'b1;
				inc     = word_mode ? pcrc_pkg::INC_ONE : pcrc_pkg::INC_TWO;
				if (stage_in) begin
					push_data    = {st_ff.stage, DATA_IN[15:8]};
					nxt_st.stage = DATA_IN[7:0];
				end
			end else if (stage_in) begin
				push_en            = 1'b1;
				push_data          = {st_ff.stage, DATA_IN[7:0]};
				nxt_st.stage_valid = 1'b0;
				inc                = pcrc_pkg::INC_ONE;
			end else begin
				nxt_st.stage       = DATA_IN[7:0];
				nxt_st.stage_valid = 1'b1;
				inc                = word_mode ? pcrc_pkg::CNT_RST : pcrc_pkg::INC_ONE;
			end
		end
		// the fifo head always comes before the staged byte
		// a staged byte is shifted only when nothing else waits
		// and only when no write is about to pair it
		// a half-shifted staged byte resumes from the fifo head after pairing
		// element source: fifo head, or a lone staged byte in byte mode only
		from_stage = !head_valid && !word_mode && st_ff.stage_valid && !DATA_WR;
		can_shift  = SHIFTER_GO_BIT && (st_ff.count != '0) && !flush &&
			(head_valid || from_stage);
		if (from_stage) begin
			elem = {8'h00, st_ff.stage};
		end else if (word_mode) begin
			elem = head_data;
		end else begin
			elem = {8'h00, (st_ff.half ? head_data[7:0] : head_data[15:8])};
		end
		pos      = 4'(POLY_LENGTH_FIELD - st_ff.done);
		din      = elem[pos];
		last_bit = (st_ff.done == POLY_LENGTH_FIELD);
		// done counts bits of the current element
		// half selects the byte within a word in byte mode
		// the head word pops after its last bit in word mode
		// or after its low byte in byte mode
		// one bit per SYS_CLK, two per instruction cycle
		if (can_shift) begin
			nxt_st.crc = crc_step;
			if (last_bit) begin
				dec         = 1'b1;
				nxt_st.done = pcrc_pkg::DONE_RST;
				if (from_stage) begin
					nxt_st.stage_valid = 1'b0;
				end else if (word_mode || st_ff.half) begin
					pop         = 1'b1;
					nxt_st.half = 1'b0;
				end else begin
					nxt_st.half = 1'b1;
				end
			end else begin
				nxt_st.done = 4'(st_ff.done + 1'b1);
			end
		end
		// direct preset of the shift register
		if (SR_WR) begin
			nxt_st.crc = SR_WDATA;
		end
		nxt_st.count = 5'(base + inc - {4'h0, dec});
		nxt_st.full  = (nxt_st.count == (word_mode ? pcrc_pkg::FULL_WORDS
			: pcrc_pkg::FULL_BYTES));
		nxt_st.empty = (nxt_st.count == '0) && !nxt_st.stage_valid;
		// the drain flag needs a shift step, so a flush never sets it
		// empty waits for the staging slot as well as the count
		// the interrupt output is the flag gated by the enable
		// drain event; a new event beats a clear in the same cycle
		irq_set = can_shift && (((st_ff.count != '0) && (nxt_st.count == '0)) ||
			(!st_ff.empty && nxt_st.empty));
		if (DRAIN_IRQ_CLEAR) begin
			nxt_st.irq = 1'b0;
		end
		if (irq_set) begin
			nxt_st.irq = 1'b1;
		end
	end

	// every field resets to a constant
	// the reset is asynchronous and acts on all fields at once
	// state register
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_ff.crc         <= pcrc_pkg::CRC_RST;
			st_ff.count       <= pcrc_pkg::CNT_RST;
			st_ff.stage       <= pcrc_pkg::BYTE_RST;
			st_ff.stage_valid <= 1'b0;
			st_ff.half        <= 1'b0;
			st_ff.done        <= pcrc_pkg::DONE_RST;
			st_ff.full        <= 1'b0;
			st_ff.empty       <= pcrc_pkg::EMPTY_RST;
			st_ff.irq         <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// data outputs come straight from flops, save the data read, a constant zero
	// ready and the status view are combinational
	// outputs
	assign DATA_WR_READY   = fifo_ready;
	assign DATA_RD_VALUE   = pcrc_pkg::DATA_READ_VALUE;
	assign SR_RDATA        = st_ff.crc;
	assign FIFO_FILL_COUNT = st_ff.count;
	assign FIFO_FULL_FLAG  = st_ff.full;
	assign FIFO_EMPTY_FLAG = st_ff.empty;
	assign DRAIN_IRQ_FLAG  = st_ff.irq;
	assign DRAIN_IRQ       = st_ff.irq && DRAIN_IRQ_ENABLE;

	// go and length bits echo the inputs
	// control and status view, unused bits read zero
	always_comb begin
		CONTROL_STATUS_REGISTER = 16'h0000;
		CONTROL_STATUS_REGISTER[pcrc_pkg::CS_CNT_MSB:pcrc_pkg::CS_CNT_LSB] = st_ff.count;
		CONTROL_STATUS_REGISTER[pcrc_pkg::CS_FULL_BIT]  = st_ff.full;
		CONTROL_STATUS_REGISTER[pcrc_pkg::CS_EMPTY_BIT] = st_ff.empty;
		CONTROL_STATUS_REGISTER[pcrc_pkg::CS_GO_BIT]    = SHIFTER_GO_BIT;
		CONTROL_STATUS_REGISTER[pcrc_pkg::CS_LEN_MSB:pcrc_pkg::CS_LEN_LSB] = POLY_LENGTH_FIELD;
	end
endmodule // pcrc_engine
`default_nettype wire

// >>> rtl/pcrc_pkg.sv
// Purpose: shared constants for the programmable crc engine with input fifo
// Assumes: one clock, SYS_CLK at 10 MHz, is also the shift clock
// Notes:   the instruction clock is taken as SYS_CLK divided by two
`default_nettype none
package pcrc_pkg;
	// clock figures
	localparam int          SYS_CLK_HZ        = 10_000_000;
	localparam int          SHIFT_PER_INSTR   = 2;             // shift clocks per instruction cycle
	// polynomial length field
	localparam int          LEN_W             = 4;
	localparam logic [3:0]  LEN_BYTE_MAX      = 4'h7;          // above this the fifo holds words
	// fill counter and limits
	localparam int          CNT_W             = 5;
	localparam logic [4:0]  FULL_WORDS        = 5'h08;
	localparam logic [4:0]  FULL_BYTES        = 5'h10;
	localparam logic [4:0]  INC_ONE           = 5'h01;
	localparam logic [4:0]  INC_TWO           = 5'h02;
	// fifo shape
	localparam int          FIFO_WIDTH        = 16;
	localparam int          FIFO_DEPTH        = 8;
	// control and status word layout
	localparam int          CS_CNT_LSB        = 8;
	localparam int          CS_CNT_MSB        = 12;
	localparam int          CS_FULL_BIT       = 7;
	localparam int          CS_EMPTY_BIT      = 6;
	localparam int          CS_GO_BIT         = 4;
	localparam int          CS_LEN_LSB        = 0;
	localparam int          CS_LEN_MSB        = 3;
	// reset and read values
	localparam logic [15:0] CRC_RST           = 16'h0000;
	localparam logic [15:0] DATA_READ_VALUE   = 16'h0000;
	localparam logic [7:0]  BYTE_RST          = 8'h00;
	localparam logic [4:0]  CNT_RST           = 5'h00;
	localparam logic [3:0]  DONE_RST          = 4'h0;
	localparam logic        EMPTY_RST         = 1'b1;
endpackage
`default_nettype wire

// >>> test/pcrc_props.sv
// Purpose: port checks for pcrc_engine
// Assumes: the length field changes only while the fifo is empty
// Notes:   bound to every pcrc_engine instance
`timescale 1ns/1ns
`default_nettype none
module pcrc_props (
	input wire logic        SYS_CLK,
	input wire logic        RST,
	input wire logic [3:0]  POLY_LENGTH_FIELD,
	input wire logic        SHIFTER_GO_BIT,
	input wire logic        DRAIN_IRQ_ENABLE,
	input wire logic        DATA_WR,
	input wire logic        DATA_WR_WORD,
	input wire logic        SR_WR,
	input wire logic [15:0] SR_WDATA,
	input wire logic [15:0] SR_RDATA,
	input wire logic [15:0] DATA_RD_VALUE,
	input wire logic [4:0]  FIFO_FILL_COUNT,
	input wire logic        FIFO_FULL_FLAG,
	input wire logic        FIFO_EMPTY_FLAG,
	input wire logic [15:0] CONTROL_STATUS_REGISTER,
	input wire logic        DRAIN_IRQ_FLAG,
	input wire logic        DRAIN_IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// port views and static relations
	AST_RD_ZERO: assert property (DATA_RD_VALUE == 16'h0000) else $error("data read not zero");
	AST_CS_VIEW: assert property (CONTROL_STATUS_REGISTER[12:8] == FIFO_FILL_COUNT
		&& CONTROL_STATUS_REGISTER[7:6] == {FIFO_FULL_FLAG, FIFO_EMPTY_FLAG}) else $error("status view");
	AST_FULL: assert property (FIFO_FULL_FLAG == (FIFO_FILL_COUNT ==
		((POLY_LENGTH_FIELD > 4'h7) ? 5'h08 : 5'h10))) else $error("full flag wrong");
	AST_IRQ: assert property (DRAIN_IRQ == (DRAIN_IRQ_FLAG && DRAIN_IRQ_ENABLE)) else $error("irq");
	// timed relations
	AST_SR_LOAD: assert property (SR_WR |=> SR_RDATA == $past(SR_WDATA)) else $error("sr load");
	AST_FREEZE: assert property (!SHIFTER_GO_BIT && !DATA_WR && !SR_WR
		|=> $stable(SR_RDATA) && $stable(FIFO_FILL_COUNT)) else $error("state moved with go low");
	AST_BYTE_INC: assert property (!SHIFTER_GO_BIT && DATA_WR && !FIFO_FULL_FLAG
		&& POLY_LENGTH_FIELD <= 4'h7 |=> FIFO_FILL_COUNT ==
		$past(FIFO_FILL_COUNT) + ($past(DATA_WR_WORD) ? 5'h02 : 5'h01)) else $error("byte count");
	AST_DEC_ONE: assert property (!DATA_WR |=> FIFO_FILL_COUNT == $past(FIFO_FILL_COUNT)
		|| FIFO_FILL_COUNT == $past(FIFO_FILL_COUNT) - 5'h01) else $error("count step");
	AST_DRAIN: assert property ($past(FIFO_FILL_COUNT) != 5'h00 && FIFO_FILL_COUNT == 5'h00
		&& !$past(DATA_WR) |-> DRAIN_IRQ_FLAG // parked byte keeps empty low
		&& (FIFO_EMPTY_FLAG || POLY_LENGTH_FIELD > 4'h7)) else $error("drain flags");
endmodule // pcrc_props
bind pcrc_engine pcrc_props u_props (.SYS_CLK, .RST, .POLY_LENGTH_FIELD, .SHIFTER_GO_BIT,
	.DRAIN_IRQ_ENABLE, .DATA_WR, .DATA_WR_WORD, .SR_WR, .SR_WDATA, .SR_RDATA, .DATA_RD_VALUE,
	.FIFO_FILL_COUNT, .FIFO_FULL_FLAG, .FIFO_EMPTY_FLAG, .CONTROL_STATUS_REGISTER,
	.DRAIN_IRQ_FLAG, .DRAIN_IRQ);
`default_nettype wire

// >>> test/pcrc_cpu.sv
// Purpose: cpu model writing the data port
// Assumes: writes launch on the falling edge of the clock
// Notes:   data lines carry inverted data between writes
`timescale 1ns/1ns
`default_nettype none
module pcrc_cpu (
	input  wire logic        sys_clk,
	output logic             data_wr,
	output logic             data_wr_word,
	output logic [15:0]      data_in
);
	// idle values
	initial begin
		data_wr = 1'b0;
		data_wr_word = 1'b0;
		data_in = 16'h0000;
	end
	// one write pulse, then wait one SYS_CLK cycle before the count is read
	task automatic wr(input logic word, input logic [15:0] d);
		@(negedge sys_clk);
		data_wr = 1'b1;
		data_wr_word = word;
		data_in = d;
		@(negedge sys_clk);
		data_wr = 1'b0;
		data_in = ~d;
		@(negedge sys_clk);
	endtask
endmodule // pcrc_cpu
`default_nettype wire

// >>> test/testbench.sv
// Purpose: self-checking bench for pcrc_engine
// Assumes: instruction clock is the system clock divided by two
// Notes:   expected crc values come from a bit-serial model here
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        sys_clk, rst, go, irq_en, irq_clr, sr_wr, full, empty, irq_flag, irq;
	logic        data_wr, data_wr_word, wr_rdy;
	logic [3:0]  len;
	logic [4:0]  fill;
	logic [15:0] tap, sr_wdata, sr_rdata, data_in, exp_crc;
	int          errors, n_tests;
	pcrc_cpu u_cpu (.sys_clk(sys_clk), .data_wr(data_wr), .data_wr_word(data_wr_word),
		.data_in(data_in));
	pcrc_engine uut (.SYS_CLK(sys_clk), .RST(rst), .POLY_LENGTH_FIELD(len),
		.POLY_TAP_REGISTER(tap), .SHIFTER_GO_BIT(go), .DRAIN_IRQ_ENABLE(irq_en),
		.DRAIN_IRQ_CLEAR(irq_clr), .DATA_WR(data_wr), .DATA_WR_WORD(data_wr_word),
		.DATA_IN(data_in), .DATA_WR_READY(wr_rdy), .DATA_RD_VALUE(), .SR_WR(sr_wr),
		.SR_WDATA(sr_wdata), .SR_RDATA(sr_rdata), .FIFO_FILL_COUNT(fill),
		.FIFO_FULL_FLAG(full), .FIFO_EMPTY_FLAG(empty), .CONTROL_STATUS_REGISTER(),
		.DRAIN_IRQ_FLAG(irq_flag), .DRAIN_IRQ(irq));
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	// serial model: one shift step and one element msb first
	function automatic logic [15:0] step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[len] ^ b;
		step = ((c << 1) ^ (tap & {16{fb}})) & (16'hFFFF >> (4'hF - len));
		step[0] = fb;
	endfunction
	task automatic feed(input logic [15:0] d);
		for (int i = 15; i >= 0; i--) begin
			if (i <= len) exp_crc = step(exp_crc, d[i]);
		end
	endtask
	task automatic set_cfg(input logic [3:0] l, input logic [15:0] t, input logic [15:0] s);
		@(negedge sys_clk);
		len = l;
		tap = t;
		sr_wr = 1'b1;
		sr_wdata = s;
		irq_clr = 1'b1; // sticky drain flag from an earlier test
		@(negedge sys_clk);
		sr_wr = 1'b0;
		irq_clr = 1'b0;
		sr_wdata = ~s;
		exp_crc = s;
	endtask
	task automatic run(input int n);
		@(negedge sys_clk);
		go = 1'b1;
		repeat (n) @(negedge sys_clk);
		go = 1'b0;
	endtask
	// sixteen-bit word, both taps differing in bit zero, split run
	task automatic t_word16;
		for (int k = 0; k < 2; k++) begin
			set_cfg(4'hF, 16'h1020 | 16'(k), 16'h0000);
			irq_en = k[0];
			u_cpu.wr(1'b1, 16'h1234);
			chk(16'h0001, 16'(fill));
			feed(16'h1234);
			run(15);
			chk(16'h0001, 16'(fill));
			run(1);
			chk(exp_crc, sr_rdata);
			chk(16'h0003, {14'h0, empty, irq_flag});
			chk(16'(k), 16'(irq));
			irq_clr = 1'b1;
			@(negedge sys_clk);
			irq_clr = 1'b0;
		end
		$display("test word16 done");
	endtask
	// six-bit poly in byte mode with a preset
	task automatic t_byte;
		set_cfg(4'h5, 16'h0012, 16'h0015);
		u_cpu.wr(1'b0, 16'h77C5);
		u_cpu.wr(1'b1, 16'hABCD);
		chk(16'h0003, 16'(fill));
		feed(16'h00C5);
		feed(16'h00AB);
		feed(16'h00CD);
		run(18);
		chk(exp_crc, sr_rdata);
		chk(16'h0000, 16'(fill));
		$display("test byte done");
	endtask
	// fill to full, then one more write flushes
	task automatic t_full;
		set_cfg(4'hF, 16'h8005, 16'h0000);
		irq_en = 1'b1;
		repeat (8) u_cpu.wr(1'b1, 16'h5A5A);
		chk(16'h0108, {7'h0, full, 3'h0, fill});
		chk(16'h0000, 16'(wr_rdy));
		u_cpu.wr(1'b1, 16'h00FF);
		chk(16'h0001, {7'h0, full, 2'h0, irq_flag, fill});
		chk(16'h0001, 16'(wr_rdy));
		feed(16'h00FF);
		run(16);
		chk(exp_crc, sr_rdata);
		$display("test full done");
	endtask
	// odd bytes in word mode leave one staged
	task automatic t_odd;
		set_cfg(4'h9, 16'h0204, 16'h0000);
		u_cpu.wr(1'b0, 16'h0012);
		chk(16'h0000, 16'(fill));
		u_cpu.wr(1'b0, 16'h0034);
		u_cpu.wr(1'b0, 16'h0056);
		chk(16'h0001, 16'(fill));
		feed(16'h1234);
		run(20);
		chk(exp_crc, sr_rdata);
		chk(16'h0000, {fill, empty});
		$display("test odd done");
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#300000;
		errors++;
		results;
	end
	initial begin
		{rst, go, irq_en, irq_clr, sr_wr, len, tap, sr_wdata} = '0;
		errors = 0;
		n_tests = 0;
		rst = 1'b1;
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		t_word16;
		t_byte;
		t_full;
		t_odd;
		results;
	end
endmodule // testbench
`default_nettype wire
